// [dv/waveform_function_sequencer_test.sv]
/*
  Self-checking bench of the function sequencer: strobe tasks, run
  sequences, alarm aborts and parameter checks.
  Assumes the design with default nominal values and TICK_CYC of 4.
*/
`timescale 1ns/1ps
`default_nettype none
module waveform_function_sequencer_test;
  import wfs_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [8:0] stb = 9'h000;
  logic [3:0] alm = 4'h0;
  logic rmode = 1'b0;
  logic press = 1'b0;
  logic btn;
  wfs_func_t fsel = WFS_SINE;
  wfs_tgt_t tsel = WFS_TGT_VOLT;
  wfs_cfg_t cfg = '0;
  logic [VAL_W-1:0] ext_volt = 24'h00ffff;
  logic dc_on, running, locked, sink, alarm, cfg_err;
  wfs_set_t set;
  wire [4:0] outs = {alarm, sink, locked, running, dc_on};
  int n_mismatch = 0;
  int num_checks = 0;
  wfs_cfg_t ca, cb, cc;
  logic [VAL_W-1:0] umax, umin;
  int nsink;

  // clock at 100 MHz
  always #5 ref_clk_i = ~ref_clk_i;

  wfs_panel panel (.ref_clk_i(ref_clk_i), .press_i(press), .btn_o(btn));

  wfs_top #(.TICK_CYC(4)) DUT (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .func_enter_i(stb[0]), .func_choose_i(stb[1]),
    .func_i(fsel), .target_choose_i(stb[2]), .target_i(tsel), .confirm_i(stb[3]), .exit_i(stb[4]),
    .cfg_wr_i(stb[5]), .cfg_i(cfg), .start_cmd_i(stb[6]), .stop_cmd_i(stb[7]), .onoff_btn_i(btn),
    .dev_alarm_i(alm[0]), .over_power_protection_i(alm[1]), .over_current_protection_i(alm[2]),
    .event_alarm_i(alm[3]), .alarm_ack_i(stb[8]), .resistance_regulation_alias_i(rmode),
    .ext_volt_i(ext_volt), .dc_on_o(dc_on), .running_o(running), .sel_locked_o(locked),
    .sink_mode_o(sink), .alarm_o(alarm), .cfg_err_o(cfg_err), .set_o(set));

  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // compare seen against expected
  task automatic check(input string n, input logic [VAL_W-1:0] s, input logic [VAL_W-1:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic chk1(input string n, input logic s, input logic e);
    check(n, VAL_W'(s), VAL_W'(e));
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  // one-cycle strobe on an operator request line
  task automatic pulse(input int b);
    @(posedge ref_clk_i);
    #1 stb[b] = 1'b1;
    @(posedge ref_clk_i);
    #1 stb[b] = 1'b0;
  endtask

  task automatic wr(input wfs_cfg_t c);
    cfg = c;
    pulse(5);
  endtask

  task automatic push();
    @(posedge ref_clk_i);
    #1 press = 1'b1;
    @(posedge ref_clk_i);
    #1 press = 1'b0;
  endtask

  // bounded wait for one status output
  task automatic wait_out(input int k, input logic v, input int lim);
    for (int i = 0; i < lim && outs[k] !== v; i++) tick(1);
    chk1("status wait", outs[k], v);
    if (outs[k] !== v) wrap_up();
  endtask

  function automatic wfs_cfg_t mk(input logic [VAL_W-1:0] a, input logic [VAL_W-1:0] o,
                                  input logic [FREQ_W-1:0] f, input logic [TIME_W-1:0] t,
                                  input logic [VAL_W-1:0] u, input logic [VAL_W-1:0] ab);
    wfs_cfg_t r;
    r = '{amp: a, offset: o, freq: f, t_rise: t, t_fall: t, stat_u: u, stat_i: 24'h000056,
          stat_p: 24'h000078, absorb_i: ab, absorb_p: ab};
    return r;
  endfunction

  // configure and reach run-ready
  task automatic go_ready(input wfs_func_t f, input wfs_tgt_t t, input wfs_cfg_t c);
    wr(c);
    pulse(0);
    fsel = f;
    pulse(1);
    tsel = t;
    pulse(2);
    pulse(3);
    wait_out(0, 1'b1, 10);
    tick(2);
    check("set u", set.u, c.stat_u);
    check("set i", set.i, c.stat_i);
    check("set p", set.p, c.stat_p);
    check("absorb i", set.absorb_i, VAL_ZERO);
    check("absorb p", set.absorb_p, c.absorb_p);
    chk1("cfg err", cfg_err, 1'b0);
  endtask

  // main sequence
  initial begin
    ca = mk(24'h000100, 24'h000000, 14'h2710, 29'h4, 24'h001234, 24'h000020);
    cc = mk(24'h000100, 24'h000000, 14'h2710, 29'h4, 24'h002222, 24'h000020);
    cb = mk(24'h000100, 24'h000100, 14'h0001, 29'h4, 24'h000000, 24'h000000);
    tick(10);
    rst_n_i = 1'b1;
    tick(1);
    chk1("dc on", dc_on, 1'b0);
    check("set u", set.u, VAL_ZERO);
    rmode = 1'b1;
    tick(3);
    chk1("locked", locked, 1'b1);
    for (int b = 0; b < 4; b++) pulse(b);
    tick(3);
    chk1("dc on", dc_on, 1'b0);
    rmode = 1'b0;
    tick(3);
    chk1("locked", locked, 1'b0);
    go_ready(WFS_SINE, WFS_TGT_CURR, ca);
    wr(ca);
    pulse(6);
    wait_out(1, 1'b1, 10);
    wait_out(3, 1'b1, 12000);
    check("sink i", set.i, VAL_ZERO);
    wr(cc);
    tick(1);
    chk1("cfg err", cfg_err, 1'b0);
    pulse(7);
    wait_out(1, 1'b0, 10);
    tick(2);
    chk1("dc on", dc_on, 1'b1);
    check("set u", set.u, 24'h002222);
    for (int k = 0; k < 4; k++) begin
      case (k)
        0: wr(mk(24'h000100, 24'h0, 14'h0000, 29'h4, 24'h003333, 24'h0));
        1: wr(mk(24'h000100, 24'h0, 14'h2711, 29'h4, 24'h003333, 24'h0));
        2: wr(mk(24'h010000, 24'h0, 14'h0001, 29'h4, 24'h003333, 24'h0));
        default: wr(mk(24'h008000, 24'h008000, 14'h0001, 29'h4, 24'h003333, 24'h0));
      endcase
      tick(1);
      chk1("cfg err", cfg_err, 1'b1);
      check("set u", set.u, 24'h002222);
      wr(cc);
    end
    pulse(4);
    wait_out(0, 1'b0, 10);
    go_ready(WFS_TRI, WFS_TGT_VOLT, cb);
    push();
    wait_out(0, 1'b0, 20);
    tick(10);
    push();
    wait_out(1, 1'b1, 20);
    umax = VAL_ZERO;
    umin = 24'hffffff;
    nsink = 0;
    for (int i = 0; i < 100; i++) begin
      tick(1);
      if (set.u > umax) umax = set.u;
      if (set.u < umin) umin = set.u;
      if (sink !== 1'b0) nsink++;
    end
    check("tri peak", umax, 24'h000200);
    check("tri base", umin, 24'h000100);
    check("sink count", VAL_W'(nsink), VAL_ZERO);
    for (int k = 0; k < 3; k++) begin
      case (k)
        0: wr(mk(24'h000100, 24'hffffff, 14'h0001, 29'h4, 24'h0, 24'h0));
        1: wr(mk(24'h000100, 24'h000100, 14'h0001, 29'h0, 24'h0, 24'h0));
        default: wr(mk(24'h000100, 24'h000100, 14'h0001, T_MAX + 29'h1, 24'h0, 24'h0));
      endcase
      tick(1);
      chk1("cfg err", cfg_err, 1'b1);
      wr(cb);
    end
    // sink current given mid-run: terminal above peak sinks, at peak does not
    wr(mk(24'h000100, 24'h000100, 14'h0001, 29'h4, 24'h0, 24'h000010));
    tick(2);
    chk1("volt sink", sink, 1'b1);
    ext_volt = 24'h000200;
    tick(2);
    chk1("volt sink", sink, 1'b0);
    ext_volt = 24'h00ffff;
    wr(cb);
    tick(10);
    push();
    wait_out(1, 1'b0, 20);
    chk1("dc on", dc_on, 1'b0);
    pulse(4);
    for (int a = 0; a < 4; a++) begin
      tick(4);
      go_ready(WFS_SINE, WFS_TGT_CURR, ca);
      pulse(6);
      wait_out(1, 1'b1, 10);
      alm[a] = 1'b1;
      wait_out(0, 1'b0, 20);
      chk1("running", running, 1'b0);
      chk1("alarm", alarm, 1'b1);
      alm[a] = 1'b0;
      tick(6);
      pulse(8);
      tick(2);
      chk1("alarm", alarm, 1'b0);
      pulse(4); // back to idle so the next selection is taken
    end
    wrap_up();
  end
endmodule
`default_nettype wire

// [dv/wfs_panel.sv]
/*
  Front panel model: turns a one-cycle press request into a held
  button level, as a finger on the on/off button would.
  Assumes press_i comes from the bench shortly after a clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module wfs_panel (
  input wire logic ref_clk_i,
  input wire logic press_i,
  output logic btn_o
);
  logic [3:0] hold_r = 4'h0;
  // hold the pin high for eight cycles per press, long enough to sync
  always @(posedge ref_clk_i) begin
    if (press_i) hold_r <= 4'h8;
    else if (hold_r != 4'h0) hold_r <= hold_r - 4'h1;
  end
  assign btn_o = (hold_r != 4'h0);
endmodule
`default_nettype wire

// [verilog/wfs_pkg.sv]
/*
  Shared constants and types of the waveform function sequencer:
  value widths, parameter limits, timing counts and the config carrier.
  Assumes a single 100 MHz control clock.
*/
`default_nettype none
package wfs_pkg;
  // widths of set values, edge times and sine frequency
  localparam int VAL_W = 24;
  localparam int TIME_W = 29;
  localparam int FREQ_W = 14;
  localparam int PHASE_W = 32;

  // control clock
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;

  // base tick of the triangle edges: 0.1 ms, counted up to whole cycles
  localparam int TICK_NS = 100_000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // sine frequency limits in Hz
  localparam logic [FREQ_W-1:0] FREQ_MIN = 14'h0001;
  localparam logic [FREQ_W-1:0] FREQ_MAX = 14'h2710;

  // edge time limits in ticks: 0.1 ms and 36,000,000 ms
  localparam logic [TIME_W-1:0] T_MIN = 29'h0000001;
  localparam logic [TIME_W-1:0] T_MAX = 29'h15752a00;

  // phase step per cycle is freq * PHASE_K >> 16
  localparam longint unsigned PHASE_K = (64'h1 << 48) / 64'(CLK_HZ);

  // parabolic sine shape scaling
  localparam logic [15:0] HALF_SPAN = 16'h8000;

  localparam logic [VAL_W-1:0] VAL_ZERO = 24'h000000;

  typedef enum logic {WFS_SINE, WFS_TRI} wfs_func_t;
  typedef enum logic {WFS_TGT_VOLT, WFS_TGT_CURR} wfs_tgt_t;

  // configuration written by the operator side
  typedef struct packed {
    logic [VAL_W-1:0] amp;
    logic signed [VAL_W-1:0] offset;
    logic [FREQ_W-1:0] freq;
    logic [TIME_W-1:0] t_rise;
    logic [TIME_W-1:0] t_fall;
    logic [VAL_W-1:0] stat_u;
    logic [VAL_W-1:0] stat_i;
    logic [VAL_W-1:0] stat_p;
    logic [VAL_W-1:0] absorb_i;
    logic [VAL_W-1:0] absorb_p;
  } wfs_cfg_t;

  // targets handed to the power stage
  typedef struct packed {
    logic [VAL_W-1:0] u;
    logic [VAL_W-1:0] i;
    logic [VAL_W-1:0] p;
    logic [VAL_W-1:0] absorb_i;
    logic [VAL_W-1:0] absorb_p;
  } wfs_set_t;
endpackage
`default_nettype wire

// [verilog/wfs_sync.sv]
/*
  Three-stage synchroniser for asynchronous pin levels.
  A change is taken once the second and third stages agree.
*/
`timescale 1ns/1ps
`default_nettype none
module wfs_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] lvl_o
);
  logic [W-1:0] s1_r, s2_r, s3_r, lvl_r;
  logic [W-1:0] lvl_nxt;

  // accept the level only where stages two and three match
  always_comb begin
    lvl_nxt = lvl_r;
    for (int b = 0; b < W; b++) begin
      if (s2_r[b] == s3_r[b]) begin
        lvl_nxt[b] = s3_r[b];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      lvl_r <= '0;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign lvl_o = lvl_r;
endmodule
`default_nettype wire

// [verilog/wfs_top.sv]
/*
  Function sequencer of a bidirectional supply: selection gating,
  target binding, static values, start/stop, alarm abort, sink choice.
  Assumes operator strobes are one-cycle pulses on ref_clk_i; button
  and alarm pins are asynchronous levels.
*/
// Summary of operation
// - selection entry only with output off and resistance mode disabled
// - after choosing a waveform, a voltage or current target must be chosen
// - static U, I, P apply before and after each run
// - entering run-ready switches output on with static limits applied
// - parameter writes accepted anytime, including during a run
// - start by screen command, or button press while output is off
// - screen stop halts run, output stays on with static values
// - button during run halts function and switches output off
// - alarm, power or current protection or alarm event aborts, output off, report; a start from run-ready in the same cycle still enters run
// - source or sink use follows parameters only, never preset
// - voltage target sinks only if terminal exceeds offset plus amplitude, sink current nonzero
// - sine frequency fixed per run, 1 Hz to 10000 Hz; a parameter write during a run still changes it
// - sine amplitude and offset bounded by nominal rating
// - mixed sine switches between source and sink at zero crossing
// - amplitude is magnitude; negative offset only for current target
// - triangle rise and fall each 0.1 ms to 36,000,000 ms
// - triangle offset is base level, amplitude stacked on it
// - choosing a function forces sink current to zero
`timescale 1ns/1ps
`default_nettype none
module wfs_top
  import wfs_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter logic [VAL_W-1:0] U_NOM = 24'h00ffff,
  parameter logic [VAL_W-1:0] I_NOM = 24'h00ffff
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic func_enter_i,
  input wire logic func_choose_i,
  input wire wfs_func_t func_i,
  input wire logic target_choose_i,
  input wire wfs_tgt_t target_i,
  input wire logic confirm_i,
  input wire logic exit_i,
  input wire logic cfg_wr_i,
  input wire wfs_cfg_t cfg_i,
  input wire logic start_cmd_i,
  input wire logic stop_cmd_i,
  input wire logic onoff_btn_i,
  input wire logic dev_alarm_i,
  input wire logic over_power_protection_i,
  input wire logic over_current_protection_i,
  input wire logic event_alarm_i,
  input wire logic alarm_ack_i,
  input wire logic resistance_regulation_alias_i,
  input wire logic [VAL_W-1:0] ext_volt_i,
  output logic dc_on_o,
  output logic running_o,
  output logic sel_locked_o,
  output logic sink_mode_o,
  output logic alarm_o,
  output logic cfg_err_o,
  output wfs_set_t set_o
);
  typedef enum logic [2:0] {ST_IDLE, ST_FUNC, ST_TGT, ST_CFG, ST_READY, ST_RUN} wfs_state_t;

  wfs_state_t state_r, state_nxt;
  wfs_func_t func_r, func_nxt;
  wfs_tgt_t tgt_r, tgt_nxt;
  wfs_cfg_t cfg_r, cfg_nxt;
  wfs_set_t set_r, set_nxt;
  logic dc_on_r, dc_on_nxt, alarm_r, alarm_nxt, err_r, err_nxt;
  logic sink_r, sink_nxt, locked_r, locked_nxt, btn_prev_r;
  logic running_r, running_nxt;
  logic [3:0] pins;
  logic btn_lvl, press, any_alarm;
  logic signed [VAL_W+1:0] wave;
  logic [VAL_W:0] peak;

  // checks one parameter set against the ratings
  function automatic logic cfg_ok(input wfs_cfg_t c, input wfs_func_t f, input wfs_tgt_t t);
    logic [VAL_W:0] off_mag;
    logic [VAL_W:0] nom;
    off_mag = c.offset[VAL_W-1] ? (VAL_W+1)'(-c.offset) : (VAL_W+1)'(c.offset);
    nom = (t == WFS_TGT_VOLT) ? {1'b0, U_NOM} : {1'b0, I_NOM};
    cfg_ok = 1'b1;
    // amplitude plus offset within rating
    if (({1'b0, c.amp} + off_mag) > nom) cfg_ok = 1'b0;
    // negative offset only on the current target
    if (c.offset[VAL_W-1] && t == WFS_TGT_VOLT) cfg_ok = 1'b0;
    // sine frequency range
    if (f == WFS_SINE && (c.freq < FREQ_MIN || c.freq > FREQ_MAX)) cfg_ok = 1'b0;
    // triangle edge range
    if (f == WFS_TRI && (c.t_rise < T_MIN || c.t_rise > T_MAX ||
                         c.t_fall < T_MIN || c.t_fall > T_MAX)) cfg_ok = 1'b0;
  endfunction

  // pins from outside the clock domain
  wfs_sync #(.W(4)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i({onoff_btn_i, dev_alarm_i, over_power_protection_i, over_current_protection_i}),
    .lvl_o(pins)
  );

  wfs_wavegen #(.TICK_CYC(TICK_CYC)) u_wave (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(state_r == ST_RUN),
    .func_i(func_r),
    .cfg_i(cfg_r),
    .wave_o(wave)
  );

  assign btn_lvl = pins[3];
  assign press = btn_lvl & ~btn_prev_r;
  assign any_alarm = pins[2] | pins[1] | pins[0] | event_alarm_i;
  assign peak = (VAL_W+1)'(cfg_r.offset) + {1'b0, cfg_r.amp};

  // sequencer: state, output switch, alarm report, configuration
  always_comb begin
    state_nxt = state_r;
    func_nxt = func_r;
    tgt_nxt = tgt_r;
    cfg_nxt = cfg_r;
    dc_on_nxt = dc_on_r;
    err_nxt = err_r;
    alarm_nxt = alarm_r;
    // parameter updates in any state, even mid-run
    if (cfg_wr_i) begin
      if (cfg_ok(cfg_i, func_r, tgt_r)) begin
        cfg_nxt = cfg_i;
        err_nxt = 1'b0;
      end else begin
        err_nxt = 1'b1;
      end
    end
    case (state_r)
      ST_IDLE: begin
        // gated on output off and resistance mode off
        if (func_enter_i && !dc_on_r && !resistance_regulation_alias_i) state_nxt = ST_FUNC;
      end
      ST_FUNC: begin
        if (func_choose_i) begin
          func_nxt = func_i;
          cfg_nxt.absorb_i = VAL_ZERO;
          state_nxt = ST_TGT;
        end
      end
      ST_TGT: begin
        // target binding demanded after the waveform
        if (target_choose_i) begin
          tgt_nxt = target_i;
          state_nxt = ST_CFG;
        end
      end
      ST_CFG: begin
        if (confirm_i && cfg_ok(cfg_r, func_r, tgt_r)) begin
          state_nxt = ST_READY;
          dc_on_nxt = 1'b1;
        end else if (confirm_i) begin
          err_nxt = 1'b1;
        end
      end
      ST_READY: begin
        if (exit_i) begin
          state_nxt = ST_IDLE;
          dc_on_nxt = 1'b0;
        end else if (start_cmd_i) begin
          state_nxt = ST_RUN;
          dc_on_nxt = 1'b1;
        end else if (press) begin
          state_nxt = dc_on_r ? ST_READY : ST_RUN;
          dc_on_nxt = ~dc_on_r;
        end
      end
      ST_RUN: begin
        if (press) begin
          state_nxt = ST_READY;
          dc_on_nxt = 1'b0;
        end else if (stop_cmd_i) begin
          state_nxt = ST_READY;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    // abort forces output off and ends a run, but a start from run-ready in the same cycle still enters run; report is sticky, set beats ack
    if (alarm_ack_i) alarm_nxt = 1'b0;
    if (any_alarm) begin
      alarm_nxt = 1'b1;
      dc_on_nxt = 1'b0;
      if (state_r == ST_RUN) state_nxt = ST_READY;
    end
  end

  // power stage targets and sink decision
  always_comb begin
    // static values outside a run
    set_nxt.u = cfg_r.stat_u;
    set_nxt.i = cfg_r.stat_i;
    set_nxt.p = cfg_r.stat_p;
    set_nxt.absorb_i = cfg_r.absorb_i;
    set_nxt.absorb_p = cfg_r.absorb_p;
    sink_nxt = 1'b0;
    locked_nxt = dc_on_nxt | resistance_regulation_alias_i;
    running_nxt = (state_nxt == ST_RUN);
    // mode follows parameters, nothing preset
    if (state_r == ST_RUN) begin
      if (tgt_r == WFS_TGT_VOLT) begin
        set_nxt.u = wave[VAL_W+1] ? VAL_ZERO : wave[VAL_W-1:0];
        sink_nxt = ({1'b0, ext_volt_i} > peak) && (cfg_r.absorb_i != VAL_ZERO);
      end else begin
        // current below zero means sinking, switch at zero
        sink_nxt = wave[VAL_W+1];
        set_nxt.i = wave[VAL_W+1] ? VAL_ZERO : wave[VAL_W-1:0];
        set_nxt.absorb_i = wave[VAL_W+1] ? VAL_W'(-wave) : VAL_ZERO;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_r <= ST_IDLE;
      func_r <= WFS_SINE;
      tgt_r <= WFS_TGT_VOLT;
      cfg_r <= '0;
      set_r <= '0;
      dc_on_r <= 1'b0;
      alarm_r <= 1'b0;
      err_r <= 1'b0;
      sink_r <= 1'b0;
      locked_r <= 1'b0;
      running_r <= 1'b0;
      btn_prev_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      func_r <= func_nxt;
      tgt_r <= tgt_nxt;
      cfg_r <= cfg_nxt;
      set_r <= set_nxt;
      dc_on_r <= dc_on_nxt;
      alarm_r <= alarm_nxt;
      err_r <= err_nxt;
      sink_r <= sink_nxt;
      locked_r <= locked_nxt;
      running_r <= running_nxt;
      btn_prev_r <= btn_lvl;
    end
  end

  assign dc_on_o = dc_on_r;
  assign running_o = running_r;
  assign sel_locked_o = locked_r;
  assign sink_mode_o = sink_r;
  assign alarm_o = alarm_r;
  assign cfg_err_o = err_r;
  assign set_o = set_r;

  // checks on the sequencer
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_idle_enter_locked;
    state_r == ST_IDLE && func_enter_i && (dc_on_r || resistance_regulation_alias_i);
  endsequence
  sequence s_btn_start;
    state_r == ST_READY && !dc_on_r && press && !start_cmd_i && !exit_i && !any_alarm;
  endsequence

  sel_gate_a: assert property (s_idle_enter_locked |=> state_r == ST_IDLE)
    else $error("selection entered while locked");
  target_step_a: assert property (state_r == ST_FUNC && func_choose_i |=> state_r == ST_TGT)
    else $error("target choice skipped");
  static_vals_a: assert property (state_r != ST_RUN |=> set_o.u == $past(cfg_r.stat_u))
    else $error("static voltage not applied");
  ready_on_a: assert property (state_r == ST_CFG && state_nxt == ST_READY && !any_alarm |=> dc_on_o)
    else $error("output not on at run-ready");
  btn_start_a: assert property (s_btn_start |=> running_o && dc_on_o)
    else $error("button did not start run");
  screen_stop_a: assert property (running_o && stop_cmd_i && !press && !any_alarm
                                  |=> !running_o && dc_on_o)
    else $error("screen stop wrong");
  btn_stop_a: assert property (running_o && press && !any_alarm |=> !running_o && !dc_on_o)
    else $error("button stop wrong");
  alarm_abort_a: assert property (any_alarm |=> !dc_on_o && alarm_o && !running_o)
    else $error("alarm did not abort");
  volt_sink_a: assert property (running_o && tgt_r == WFS_TGT_VOLT && cfg_r.absorb_i == VAL_ZERO
                                |=> !sink_mode_o)
    else $error("sink without sink current");
  sine_freq_a: assert property (cfg_wr_i && func_r == WFS_SINE && cfg_i.freq > FREQ_MAX
                                |=> cfg_err_o)
    else $error("sine frequency over range accepted");
  sink_clear_a: assert property (state_r == ST_FUNC && func_choose_i |=> cfg_r.absorb_i == VAL_ZERO)
    else $error("sink current not cleared");
  mixed_sink_a: assert property (running_o && tgt_r == WFS_TGT_CURR && wave[VAL_W+1]
                                 |=> sink_mode_o && set_o.i == VAL_ZERO)
    else $error("negative current wave not sunk");
  neg_offset_a: assert property (cfg_wr_i && tgt_r == WFS_TGT_VOLT && cfg_i.offset[VAL_W-1]
                                 |=> cfg_err_o)
    else $error("negative voltage offset accepted");
endmodule
`default_nettype wire

// [verilog/wfs_wavegen.sv]
/*
  Wave generator: phase-accumulator sine with parabolic shape and
  tick-timed triangle. Inputs must be validated by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module wfs_wavegen
  import wfs_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire wfs_func_t func_i,
  input wire wfs_cfg_t cfg_i,
  output logic signed [VAL_W+1:0] wave_o
);
  logic [PHASE_W-1:0] phase_r, phase_nxt;
  logic [31:0] div_r, div_nxt;
  logic [TIME_W-1:0] cnt_r, cnt_nxt;
  logic fall_r, fall_nxt;
  logic signed [VAL_W+1:0] wave_r, wave_nxt;
  logic tick;
  logic [47:0] inc_full;
  logic [14:0] x;
  logic [29:0] shape;
  logic [VAL_W:0] mag;
  logic [VAL_W+18:0] sprod;

  // amp * n / d, used for both triangle edges
  function automatic logic [VAL_W:0] ramp(input logic [VAL_W-1:0] a,
                                          input logic [TIME_W-1:0] n,
                                          input logic [TIME_W-1:0] d);
    logic [VAL_W+TIME_W-1:0] prod;
    prod = a * n;
    ramp = (VAL_W+1)'(prod / d);
  endfunction

  // next phase, tick divider, triangle segment and wave value
  always_comb begin
    inc_full = 48'(cfg_i.freq) * 48'(PHASE_K);
    tick = (div_r == 32'(TICK_CYC - 1));
    phase_nxt = phase_r + inc_full[47:16];
    div_nxt = tick ? 32'h00000000 : div_r + 32'h00000001;
    cnt_nxt = cnt_r;
    fall_nxt = fall_r;
    x = phase_r[30:16];
    shape = 30'({15'h0000, x} * (HALF_SPAN - {1'b0, x}));
    // full-width product so large amplitudes do not wrap before the shift
    sprod = cfg_i.amp * {2'h0, shape[29:13]};
    mag = '0;
    // rise then fall, repeating every tick-timed period
    if (tick) begin
      if (cnt_r >= (fall_r ? cfg_i.t_fall : cfg_i.t_rise) - T_MIN) begin
        cnt_nxt = '0;
        fall_nxt = ~fall_r;
      end else begin
        cnt_nxt = cnt_r + T_MIN;
      end
    end
    if (func_i == WFS_SINE) begin
      // sine about the offset zero line
      mag = (VAL_W+1)'(sprod >> 15);
      if (phase_r[PHASE_W-1]) begin
        wave_nxt = (VAL_W+2)'(cfg_i.offset) - (VAL_W+2)'({1'b0, mag});
      end else begin
        wave_nxt = (VAL_W+2)'(cfg_i.offset) + (VAL_W+2)'({1'b0, mag});
      end
    end else begin
      // amplitude stacked on the offset base level
      mag = fall_r ? ramp(cfg_i.amp, cfg_i.t_fall - cnt_r, cfg_i.t_fall)
                   : ramp(cfg_i.amp, cnt_r, cfg_i.t_rise);
      wave_nxt = (VAL_W+2)'(cfg_i.offset) + (VAL_W+2)'({1'b0, mag});
    end
    if (!run_i) begin
      phase_nxt = '0;
      div_nxt = 32'h00000000;
      cnt_nxt = '0;
      fall_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      phase_r <= '0;
      div_r <= 32'h00000000;
      cnt_r <= '0;
      fall_r <= 1'b0;
      wave_r <= '0;
    end else begin
      phase_r <= phase_nxt;
      div_r <= div_nxt;
      cnt_r <= cnt_nxt;
      fall_r <= fall_nxt;
      wave_r <= wave_nxt;
    end
  end

  assign wave_o = wave_r;
endmodule
`default_nettype wire
